// ---- core/asrc_ctrl.sv ----
/*
  Host controller for a 16-bit (or strapped 8-bit) asynchronous static memory.
  Drives address, selects, strobes and data pins from a request/answer port.
  Assumes the memory's inputs are sampled synchronously to core_clk_i.
*/
`timescale 1ns/1ps
`include "asrc_regs.svh"
// Overview of operation
// RULE1 - Width strap high selects two million sixteen-bit words, both lanes used.
// RULE2 - Strap low gives byte mode; top address bit active, lanes unused.
// RULE3 - Wait at least 200 us after supply settles before any access.
// RULE4 - Write only while strobe, both selects and a lane select are active.
// RULE5 - Write data stable 25 ns before and 0 ns after write end.
// RULE6 - Write cycle at least 55 ns; strobe, select, lane pulses 40 ns.
// RULE7 - Address valid at write start, 40 ns before end, held after.
// RULE8 - Read cycle at least 55 ns; data valid by 55 ns.
// RULE9 - Data valid within 25 ns of output drive enable falling.
// RULE10 - Lane data valid within 55 ns of its lane select falling.
// RULE11 - Old data held at least 6 ns after address change.
// RULE12 - Outputs float within 18 ns of disable, 20 ns after strobe falls.
// RULE13 - Memory starts driving no sooner than 5 or 10 ns.
// RULE14 - Memory deselected when a select inactive or both lanes high.
// RULE15 - Deselect before supply drop; wait 55 ns after recovery. Code deselects and waits only for a drop seen in idle.
// RULE16 - During reads strobe stays high, selects active, drive enable low.
// RULE17 - Selects released together with strobe high keep outputs floating.
module asrc_ctrl
  import asrc_pkg::*;
(
  input  wire logic                    core_clk_i,      // Core clock, 250 MHz
  input  wire logic                    reset_i,         // Sync reset, active high
  input  wire logic                    width_strap_i,   // High: 16-bit mode
  input  wire logic                    supply_ok_i,     // Supply settled
  input  wire logic                    req_valid_i,     // Request present
  input  wire logic                    req_write_i,     // 1 write, 0 read
  input  wire logic [`ASRC_ADDR_W-1:0] req_addr_i,      // Word or byte address
  input  wire logic [1:0]              req_lanes_i,     // Lane enables, bit1 upper
  input  wire logic [`ASRC_DATA_W-1:0] req_wdata_i,     // Write data
  output logic                         req_ready_o,     // Request taken
  output logic                         rsp_valid_o,     // Read data pulse
  output logic [`ASRC_DATA_W-1:0]      rsp_rdata_o,     // Read data
  output logic [`ASRC_ADDR_W-1:0]      mem_addr_o,      // Address pins
  output logic                         chip_select_low_n_o,   // Active low select
  output logic                         chip_select_high_o,    // Active high select
  output logic                         write_strobe_n_o,      // Write strobe
  output logic                         output_drive_en_n_o,   // Output drive enable
  output logic                         upper_byte_lane_select_n_o, // Upper lane
  output logic                         lower_byte_lane_select_n_o, // Lower lane
  input  wire logic [`ASRC_DATA_W-1:0] mem_data_i,      // Data pins in
  output logic [`ASRC_DATA_W-1:0]      mem_data_o,      // Data pins out
  output logic                         mem_data_oe_n_o  // Low while driving
);
  import asrc_pkg::*;

  asrc_state_t            state_reg;
  asrc_state_t            state_next;
  logic [`ASRC_ADDR_W-1:0] addr_reg;
  logic [`ASRC_DATA_W-1:0] wdata_reg;
  logic [`ASRC_DATA_W-1:0] rdata_reg;
  logic [1:0]              lanes_reg;
  logic                    rsp_reg;
  logic                    tmr_load;
  logic [`ASRC_CNT_W-1:0]  tmr_value;
  logic                    tmr_done;
  logic                    take;
  logic                    selected;
  logic [1:0]              lanes_eff;
  logic [`ASRC_ADDR_W-1:0] addr_eff;
  logic [15:0]             pu_cnt_reg;
  logic                    pu_done;

  // Byte mode: lower lane select only, top address bit carries the byte choice
  assign lanes_eff = width_strap_i ? req_lanes_i : 2'b01;   // see RULE1 see RULE2
  assign addr_eff  = width_strap_i ? {1'b0, req_addr_i[`ASRC_ADDR_W-2:0]} : req_addr_i;

  assign take        = (state_reg == ASRC_IDLE) && req_valid_i && supply_ok_i;
  assign req_ready_o = take;
  assign rsp_valid_o = rsp_reg;
  assign rsp_rdata_o = rdata_reg;

  // Selects asserted only in an access; otherwise deselected for standby
  assign selected = (state_reg == ASRC_READ) || (state_reg == ASRC_WRITE)
                    || (state_reg == ASRC_WR_END);                         // see RULE14
  assign mem_addr_o          = addr_reg;                                   // see RULE7
  assign chip_select_low_n_o = !selected;                                  // see RULE15
  assign chip_select_high_o  = selected;                                   // see RULE17
  assign write_strobe_n_o    = !(state_reg == ASRC_WRITE);                 // see RULE4 see RULE16
  assign output_drive_en_n_o = !(state_reg == ASRC_READ);                  // see RULE16
  assign upper_byte_lane_select_n_o = !(selected && lanes_reg[1]);
  assign lower_byte_lane_select_n_o = !(selected && lanes_reg[0]);
  assign mem_data_o      = wdata_reg;                                      // see RULE5
  // Drive through write end so hold is satisfied; never while reading
  assign mem_data_oe_n_o = !((state_reg == ASRC_WRITE) || (state_reg == ASRC_WR_END));

  always_comb
  begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    case (state_reg)
      ASRC_POWERUP:
        if (pu_done)
          state_next = ASRC_IDLE;                                          // see RULE3
      ASRC_IDLE:
        if (!supply_ok_i)
          state_next = ASRC_RETAIN;
        else if (take)
        begin
          state_next = req_write_i ? ASRC_WRITE : ASRC_READ;
          tmr_load   = 1'b1;
          tmr_value  = req_write_i ? `ASRC_CNT_W'(`ASRC_CYCLE_CYC)
                                   : `ASRC_CNT_W'(`ASRC_CYCLE_CYC);       // see RULE6 see RULE8
        end
      ASRC_READ:
        if (tmr_done)
          state_next = ASRC_TURN;                                          // see RULE8 see RULE9 see RULE10
      ASRC_WRITE:
        if (tmr_done)
          state_next = ASRC_WR_END;                                        // see RULE6
      ASRC_WR_END:
        state_next = ASRC_IDLE;                                            // see RULE7
      ASRC_TURN:
      begin
        // One-cycle bus turnaround; the next drive can start 8 ns after the read, inside the 18 ns float time
        state_next = ASRC_IDLE;                                            // see RULE12 see RULE13
      end
      ASRC_RETAIN:
        if (supply_ok_i)
        begin
          state_next = ASRC_RECOVER;
          tmr_load   = 1'b1;
          tmr_value  = `ASRC_CNT_W'(`ASRC_RECOVERY_CYC);
        end
      ASRC_RECOVER:
        if (tmr_done)
          state_next = ASRC_IDLE;                                          // see RULE15
      default:
        state_next = ASRC_IDLE;
    endcase
  end

  asrc_timer u_timer
  (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (tmr_load),
    .value_i    (tmr_value),
    .done_o     (tmr_done)
  );

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      state_reg <= ASRC_POWERUP;
    else
      state_reg <= state_next;
  end

  // Power-up wait runs once per reset; a later supply dip seen in idle uses the short recovery wait
  assign pu_done = (pu_cnt_reg == 16'(`ASRC_POWERUP_CYC - 1));
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      pu_cnt_reg <= '0;
    else if (supply_ok_i && !pu_done)
      pu_cnt_reg <= pu_cnt_reg + 16'h0001;                                 // see RULE3
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      lanes_reg <= '0;
    end
    else if (take)
    begin
      addr_reg  <= addr_eff;
      wdata_reg <= req_wdata_i;
      lanes_reg <= lanes_eff;
    end
  end

  // Sample at the end of the full read cycle, after all access times
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
    end
    else
    begin
      rsp_reg <= (state_reg == ASRC_READ) && tmr_done;
      if ((state_reg == ASRC_READ) && tmr_done)
        rdata_reg <= width_strap_i ? mem_data_i : {8'h00, mem_data_i[7:0]};
    end
  end

  a_read_strobe_high: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE16
    !output_drive_en_n_o |-> write_strobe_n_o && !chip_select_low_n_o)
    else $error("strobe low during read");
  a_write_pulse_len: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE6
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*8])
    else $error("write pulse too short");
  a_write_data_hold: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE5
    $rose(write_strobe_n_o) |-> !mem_data_oe_n_o && $stable(mem_data_o))
    else $error("write data not held");
  a_write_addr_hold: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE7
    !write_strobe_n_o |=> $stable(mem_addr_o))
    else $error("address moved in write");
  a_no_drive_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE12
    !output_drive_en_n_o |-> mem_data_oe_n_o)
    else $error("bus contention");
  a_read_len: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE8
    $fell(output_drive_en_n_o) |-> !output_drive_en_n_o [*8])
    else $error("read too short");
  a_powerup_wait: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE3
    req_ready_o |-> pu_done)
    else $error("access before power-up wait");
  a_retain_desel: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE15
    (state_reg == ASRC_RETAIN) |-> chip_select_low_n_o && !chip_select_high_o)
    else $error("selected in retention");
  a_write_selects: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE4
    !write_strobe_n_o |-> !chip_select_low_n_o && chip_select_high_o
                          && !(upper_byte_lane_select_n_o && lower_byte_lane_select_n_o))
    else $error("write strobe without selects");
  a_byte_upper_idle: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE2
    !width_strap_i && (state_reg != ASRC_IDLE) |-> upper_byte_lane_select_n_o)
    else $error("upper lane used in byte mode");
  c_byte_read: cover property (@(posedge core_clk_i) rsp_valid_o && !width_strap_i);
  c_read: cover property (@(posedge core_clk_i) rsp_valid_o);
  c_write: cover property (@(posedge core_clk_i) $rose(write_strobe_n_o));
  c_retain: cover property (@(posedge core_clk_i) state_reg == ASRC_RETAIN);
endmodule

// ---- core/asrc_regs.svh ----
/*
  Timing constants and pin widths of the asynchronous memory controller.
  Assumes a 250 MHz core clock (4 ns period).
*/
`ifndef ASRC_REGS_SVH
`define ASRC_REGS_SVH
`define ASRC_CLK_PERIOD_PS    4000
`define ASRC_ADDR_W           22
`define ASRC_DATA_W           16
`define ASRC_POWERUP_US       200
`define ASRC_POWERUP_CYC      (`ASRC_POWERUP_US * 1000000 / `ASRC_CLK_PERIOD_PS)
`define ASRC_RECOVERY_NS      55
`define ASRC_RECOVERY_CYC     ((`ASRC_RECOVERY_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_CYCLE_NS         55
`define ASRC_CYCLE_CYC        ((`ASRC_CYCLE_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_PULSE_NS         40
`define ASRC_PULSE_CYC        ((`ASRC_PULSE_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_SETUP_NS         25
`define ASRC_SETUP_CYC        ((`ASRC_SETUP_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_HZ_NS            20
`define ASRC_HZ_CYC           ((`ASRC_HZ_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_CNT_W            16
`endif

// ---- core/asrc_pkg.sv ----
/*
  Types of the asynchronous memory controller.
  Assumes asrc_regs.svh for all figures.
*/
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_POWERUP,
    ASRC_IDLE,
    ASRC_READ,
    ASRC_WRITE,
    ASRC_WR_END,
    ASRC_TURN,
    ASRC_RETAIN,
    ASRC_RECOVER
  } asrc_state_t;
endpackage

// ---- core/asrc_timer.sv ----
/*
  Down counter with load; done is high when the count is zero and no load is present.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "asrc_regs.svh"
module asrc_timer
(
  input  wire logic                   core_clk_i, // Core clock
  input  wire logic                   reset_i,    // Sync reset
  input  wire logic                   load_i,     // Load pulse
  input  wire logic [`ASRC_CNT_W-1:0] value_i,    // Cycles to wait
  output logic                        done_o      // Count expired
);
  logic [`ASRC_CNT_W-1:0] cnt_reg;
  logic [`ASRC_CNT_W-1:0] cnt_next;

  assign cnt_next = load_i ? value_i : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
  assign done_o   = (cnt_reg == '0) && !load_i;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule

// ---- bench/asrc_sram_model.sv ----
/*
  Behavioural model of the asynchronous static memory behind the controller.
  Assumes the bench resolves the data pins from both drivers.
*/
`timescale 1ns/1ps
module asrc_sram_model
#(
  parameter int ACC_NS = 10
)
(
  input  wire logic        strap_i,  // High: 16-bit mode
  input  wire logic [21:0] addr_i,   // Address pins
  input  wire logic        cs_n_i,   // Active low select
  input  wire logic        cs_i,     // Active high select
  input  wire logic        we_n_i,   // Write strobe
  input  wire logic        oe_n_i,   // Output drive enable
  input  wire logic [1:0]  lane_n_i, // Lane selects, bit1 upper
  input  wire logic [15:0] d_i,      // Resolved data pins
  output logic      [15:0] q_o       // Memory side of the data pins
);
  logic [15:0] mem [logic [21:0]];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rword, old, wdat;
  logic [21:0] wkey;
  logic [1:0]  wlane;
  wire  [1:0]  lane = strap_i ? ~lane_n_i : 2'h1;
  wire         sel  = !cs_n_i && cs_i && (lane != 2'h0);
  wire         wr   = sel && !we_n_i;
  wire         rd   = sel && we_n_i && !oe_n_i;
  wire  [21:0] key  = strap_i ? {1'b0, addr_i[20:0]} : addr_i;
  wire #(ACC_NS) rd_late = rd;
  // Read word follows the address late, so old data outlives an address change
  wire  [21:0] #6 key_old = key;
  // Turn-off is immediate, turn-on late: the worst case a host may meet
  wire         drv  = rd && rd_late;

  always @*
    if (wr)
    begin
      wkey = key;
      wlane = lane;
      wdat = d_i;
    end

  always @(negedge wr)
  begin
    old = mem.exists(wkey) ? mem[wkey] : 16'h0000;
    if (wlane[0]) old[7:0] = wdat[7:0];
    if (wlane[1]) old[15:8] = wdat[15:8];
    mem[wkey] = old;
  end

  // Undriven pins show the inverse of the last value, never a lucky match
  always @(key_old or drv or lane or last_q)
  begin
    rword = mem.exists(key_old) ? mem[key_old] : ~last_q;
    q_o = ~last_q;
    if (drv && lane[0]) q_o[7:0] = rword[7:0];
    if (drv && lane[1]) q_o[15:8] = rword[15:8];
  end

  // Only driven lanes are remembered, so a floating lane keeps one settled value
  always @(q_o)
  begin
    if (drv && lane[0]) last_q[7:0] = q_o[7:0];
    if (drv && lane[1]) last_q[15:8] = q_o[15:8];
  end
endmodule

// ---- bench/tb.sv ----
/*
  Self-checking bench of the memory controller against the memory model.
  Assumes the fixed power-up wait of the controller, about 50000 cycles.
*/
`timescale 1ns/1ps
`include "asrc_regs.svh"
module tb;
  typedef struct packed {
    logic        w;
    logic        s;
    logic [21:0] a;
    logic [1:0]  l;
    logic [15:0] d;
  } asrc_row_t;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        strap = 1'b1;
  logic        sok   = 1'b1;
  logic        vld   = 1'b0;
  logic        wrq   = 1'b0;
  logic [21:0] addr  = 22'h000000;
  logic [1:0]  lanes = 2'h3;
  logic [15:0] wd    = 16'h0000;
  int          error_cnt = 0;
  int          checks    = 0;
  int          wlow      = 0;
  int          n;
  logic        rdy, rsp, cs_n, cs, we_n, oe_n, ub_n, lb_n, dq_oe_n;
  logic [15:0] rdata, dq_o, q, dq;
  logic [21:0] ma;
  // Reads carry the expected word in d; byte mode compares the low byte only
  asrc_row_t   rows [10] = '{
    '{1'b1, 1'b1, 22'h000010, 2'h3, 16'ha5c3},
    '{1'b1, 1'b1, 22'h1fffff, 2'h3, 16'h0ff0},
    '{1'b1, 1'b1, 22'h000010, 2'h1, 16'h1177},
    '{1'b1, 1'b1, 22'h000010, 2'h2, 16'h3c99},
    '{1'b0, 1'b1, 22'h000010, 2'h3, 16'h3c77},
    '{1'b0, 1'b1, 22'h1fffff, 2'h3, 16'h0ff0},
    '{1'b1, 1'b0, 22'h200020, 2'h3, 16'h00b4},
    '{1'b1, 1'b0, 22'h000020, 2'h3, 16'h0069},
    '{1'b0, 1'b0, 22'h200020, 2'h3, 16'h00b4},
    '{1'b0, 1'b0, 22'h000020, 2'h3, 16'h0069}
  };

  assign dq = !dq_oe_n ? dq_o : q;

  initial forever #2 clk = ~clk;

  asrc_ctrl dut_u
  (
    .core_clk_i                 (clk),
    .reset_i                    (rst),
    .width_strap_i              (strap),
    .supply_ok_i                (sok),
    .req_valid_i                (vld),
    .req_write_i                (wrq),
    .req_addr_i                 (addr),
    .req_lanes_i                (lanes),
    .req_wdata_i                (wd),
    .req_ready_o                (rdy),
    .rsp_valid_o                (rsp),
    .rsp_rdata_o                (rdata),
    .mem_addr_o                 (ma),
    .chip_select_low_n_o        (cs_n),
    .chip_select_high_o         (cs),
    .write_strobe_n_o           (we_n),
    .output_drive_en_n_o        (oe_n),
    .upper_byte_lane_select_n_o (ub_n),
    .lower_byte_lane_select_n_o (lb_n),
    .mem_data_i                 (dq),
    .mem_data_o                 (dq_o),
    .mem_data_oe_n_o            (dq_oe_n)
  );

  asrc_sram_model #(.ACC_NS(`ASRC_CYCLE_NS)) mem_u
  (
    .strap_i  (strap),
    .addr_i   (ma),
    .cs_n_i   (cs_n),
    .cs_i     (cs),
    .we_n_i   (we_n),
    .oe_n_i   (oe_n),
    .lane_n_i ({ub_n, lb_n}),
    .d_i      (dq),
    .q_o      (q)
  );

  task automatic end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // n returns the falling edges spent waiting for the request to be taken
  task automatic op(input asrc_row_t r, output int n);
    int j;
    @(negedge clk);
    {wrq, strap, addr, lanes, wd} = r;
    vld = 1'b1;
    n = 0;
    #1;
    while (rdy !== 1'b1)
    begin
      @(negedge clk);
      #1;
      n++;
      if (n > 60000)
      begin
        error_cnt++;
        end_sim;
      end
    end
    j = 0;
    do
    begin
      @(negedge clk);
      vld = 1'b0;
      j++;
    end
    while (!r.w && rsp !== 1'b1 && j < 40);
    if (!r.w)
    begin
      check(j, 16);
      check(r.s ? rdata : {8'h00, rdata[7:0]}, r.d);
    end
  endtask

  always @(negedge clk)
  begin
    if (we_n === 1'b0)
      wlow++;
    else if (wlow != 0)
    begin
      check(wlow >= `ASRC_PULSE_CYC, 1);
      wlow = 0;
    end
    if (oe_n === 1'b0)
      check({we_n, cs_n, cs, dq_oe_n}, 4'hb);
  end

  initial
  begin
    repeat (16) @(negedge clk);
    check({we_n, cs_n, cs, oe_n, dq_oe_n}, 5'h1b);
    rst = 1'b0;
    op(rows[0], n);
    check(n + 2 > `ASRC_POWERUP_CYC, 1);
    for (int i = 1; i < 10; i++)
      op(rows[i], n);
    // Supply drop while a request waits: it must stay refused and deselected
    @(negedge clk);
    sok = 1'b0;
    vld = 1'b1;
    repeat (4) @(negedge clk);
    check({cs_n, cs, rdy}, 3'h4);
    sok = 1'b1;
    op(rows[4], n);
    check(n + 1 >= `ASRC_RECOVERY_CYC, 1);
    end_sim;
  end
endmodule
